// >>> rtl/ddr3_cmd_addr_cke_inputs.sv
// Command, address and clock-enable front end of a two-rank DDR3 device.
`timescale 1ns/10ps
module ddr3_cmd_addr_cke_inputs (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Command and address pins.
  input wire logic [1:0] cke,
  input wire logic [1:0] cs_n,
  input wire logic [1:0] odt,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bank_addr,
  input wire logic [14:0] addr,
  // Decoded command.
  output logic act_pulse,
  output logic read_pulse,
  output logic write_pulse,
  output logic pre_pulse,
  output logic mode_pulse,
  output logic mode_error,
  output logic cmd_rank,
  output logic [2:0] cmd_bank,
  output logic [14:0] row_addr,
  output logic [10:0] col_addr,
  output logic auto_precharge_bit,
  output logic pre_all,
  output logic [3:0] burst_length,
  output logic [1:0] mode_index,
  // Array and mode state.
  output logic [1:0][7:0] open_banks,
  output logic [1:0][3:0][14:0] mode_image,
  output logic [1:0] odt_active,
  // Power state per rank.
  output ddr3_cai_pkg::pwr_t [1:0] pwr_state,
  output logic [1:0] core_en,
  output logic [1:0] cmd_buf_en,
  output logic [1:0] ck_buf_en,
  // Read data strobe.
  output logic dqs_out,
  output logic dqs_oe
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cke;
    logic [1:0] cs_n;
    logic [1:0] odt;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic mrs;
    logic merr;
    logic rank;
    logic [2:0] bank;
    logic [14:0] row;
    logic [10:0] col;
    logic ap;
    logic pall;
    logic [3:0] beats;
    logic [1:0] midx;
    logic [1:0][7:0] open;
    logic [1:0][3:0][14:0] mode;
    logic [1:0] odt_on;
    logic [3:0] dqs_cnt;
    logic dqs;
    logic dqs_oe;
  } core_t;

  core_t q_reg;
  core_t q_next;
  pins_t pins;
  ddr3_cai_pkg::cmd_t cmd;
  logic [1:0] hit;

  // Burst length from mode register zero and the chop address bit.
  function automatic logic [3:0] burst_of(input logic [1:0] field, input logic chop_n);
    if (field == ddr3_cai_pkg::BL_OTF) begin
      burst_of = chop_n ? ddr3_cai_pkg::BEATS_FULL : ddr3_cai_pkg::BEATS_CHOP;
    end else if (field == ddr3_cai_pkg::BL_FIXED_4) begin
      burst_of = ddr3_cai_pkg::BEATS_CHOP;
    end else begin
      burst_of = ddr3_cai_pkg::BEATS_FULL;
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin capture and command decode
  // ---------------------------------------------------------------
  // Gather the pins into one word for the synchroniser.
  assign pins = '{cke: cke, cs_n: cs_n, odt: odt, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
                  ba: bank_addr, addr: addr};

  // Command code from the second synchroniser stage.
  assign cmd = ddr3_cai_pkg::cmd_t'({q_reg.s2.ras_n, q_reg.s2.cas_n, q_reg.s2.we_n});

  // A rank takes a command only when selected, enabled and awake.
  assign hit = ~q_reg.s2.cs_n & q_reg.s2.cke & cmd_buf_en;

  // ---------------------------------------------------------------
  // Per-rank power state machines
  // ---------------------------------------------------------------
  for (genvar gi = 0; gi < ddr3_cai_pkg::RANKS; gi++) begin : g_rank
    rank_pwr_if pif ();
    rank_power u_power (
      .clk(clk),
      .nrst(nrst),
      .p(pif.rank)
    );
    // Enable and bank state feed the rank; its registered state comes back.
    assign pif.cke = q_reg.s2.cke[gi];
    assign pif.refresh_sel = !q_reg.s2.cs_n[gi] && (cmd == ddr3_cai_pkg::CMD_REF);
    assign pif.banks_idle = ~|q_reg.open[gi];
    assign pwr_state[gi] = pif.state;
    assign core_en[gi] = pif.core_en;
    assign cmd_buf_en[gi] = pif.cmd_buf_en;
    assign ck_buf_en[gi] = pif.ck_buf_en;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Decode the sampled command, update banks and mode registers, run the strobe.
  always_comb begin
    logic r;
    logic [2:0] b;
    r = !hit[0];
    b = q_reg.s2.ba;
    q_next = q_reg;
    q_next.s1 = pins;
    q_next.s2 = q_reg.s1;
    q_next.act = 1'b0;
    q_next.rd = 1'b0;
    q_next.wr = 1'b0;
    q_next.pre = 1'b0;
    q_next.mrs = 1'b0;
    q_next.merr = 1'b0;
    for (int i = 0; i < ddr3_cai_pkg::RANKS; i++) begin
      if (hit[i]) begin
        unique case (cmd)
          ddr3_cai_pkg::CMD_ACT: begin
            q_next.open[i][b] = 1'b1;
          end
          ddr3_cai_pkg::CMD_RD, ddr3_cai_pkg::CMD_WR: begin
            if (q_reg.s2.addr[ddr3_cai_pkg::AP_BIT]) begin
              q_next.open[i][b] = 1'b0;
            end
          end
          ddr3_cai_pkg::CMD_PRE: begin
            if (q_reg.s2.addr[ddr3_cai_pkg::AP_BIT]) begin
              q_next.open[i] = '0;
            end else begin
              q_next.open[i][b] = 1'b0;
            end
          end
          ddr3_cai_pkg::CMD_MRS: begin
            if (!b[2]) begin
              q_next.mode[i][b[1:0]] = q_reg.s2.addr;
            end
          end
          ddr3_cai_pkg::CMD_REF, ddr3_cai_pkg::CMD_ZQ, ddr3_cai_pkg::CMD_NOP: begin
          end
        endcase
      end
      // Termination input is heard unless the rank sleeps in self refresh.
      q_next.odt_on[i] = q_reg.s2.odt[i] && ck_buf_en[i];
    end
    // Report the lowest selected rank's command.
    if (|hit) begin
      q_next.rank = r;
      q_next.bank = b;
      q_next.act = (cmd == ddr3_cai_pkg::CMD_ACT);
      q_next.rd = (cmd == ddr3_cai_pkg::CMD_RD);
      q_next.wr = (cmd == ddr3_cai_pkg::CMD_WR);
      q_next.pre = (cmd == ddr3_cai_pkg::CMD_PRE);
      q_next.mrs = (cmd == ddr3_cai_pkg::CMD_MRS) && !b[2];
      q_next.merr = (cmd == ddr3_cai_pkg::CMD_MRS) && b[2];
      if (cmd == ddr3_cai_pkg::CMD_ACT) begin
        q_next.row = q_reg.s2.addr;
      end
      if (cmd == ddr3_cai_pkg::CMD_RD || cmd == ddr3_cai_pkg::CMD_WR) begin
        q_next.col = {q_reg.s2.addr[ddr3_cai_pkg::COL_HI_BIT], q_reg.s2.addr[9:0]};
        q_next.ap = q_reg.s2.addr[ddr3_cai_pkg::AP_BIT];
        q_next.beats = burst_of(q_reg.mode[r][0][ddr3_cai_pkg::BL_LSB +: 2],
                                q_reg.s2.addr[ddr3_cai_pkg::BC_BIT]);
      end
      if (cmd == ddr3_cai_pkg::CMD_PRE) begin
        q_next.pall = q_reg.s2.addr[ddr3_cai_pkg::AP_BIT];
      end
      if (cmd == ddr3_cai_pkg::CMD_MRS) begin
        q_next.midx = b[1:0];
      end
    end
    // Strobe toggles on each rising clock edge, one edge per beat of the burst.
    q_next.dqs_oe = (q_reg.dqs_cnt != 4'h0);
    if (q_reg.dqs_cnt != 4'h0) begin
      q_next.dqs = !q_reg.dqs;
      q_next.dqs_cnt = q_reg.dqs_cnt - 4'h1;
    end
    if (q_next.rd) begin
      q_next.dqs_cnt = q_next.beats;
    end
  end

  // Single state register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_reg <= '0;
      q_reg.mode <= {(ddr3_cai_pkg::RANKS * ddr3_cai_pkg::MODE_REGS){ddr3_cai_pkg::MODE_RESET}};
    end else begin
      q_reg <= q_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign act_pulse = q_reg.act;
  assign read_pulse = q_reg.rd;
  assign write_pulse = q_reg.wr;
  assign pre_pulse = q_reg.pre;
  assign mode_pulse = q_reg.mrs;
  assign mode_error = q_reg.merr;
  assign cmd_rank = q_reg.rank;
  assign cmd_bank = q_reg.bank;
  assign row_addr = q_reg.row;
  assign col_addr = q_reg.col;
  assign auto_precharge_bit = q_reg.ap;
  assign pre_all = q_reg.pall;
  assign burst_length = q_reg.beats;
  assign mode_index = q_reg.midx;
  assign open_banks = q_reg.open;
  assign mode_image = q_reg.mode;
  assign odt_active = q_reg.odt_on;
  assign dqs_out = q_reg.dqs;
  assign dqs_oe = q_reg.dqs_oe;

  a_act_row_bank: assert property (@(posedge clk) disable iff (!nrst)
    (|hit && cmd == ddr3_cai_pkg::CMD_ACT)
    |=> act_pulse && row_addr == $past(q_reg.s2.addr) && open_banks[cmd_rank][cmd_bank])
    else $error("ACTIVATE row or bank not taken.");
  a_ap_flag: assert property (@(posedge clk) disable iff (!nrst)
    (read_pulse || write_pulse) |-> auto_precharge_bit == $past(q_reg.s2.addr[10]))
    else $error("Auto-precharge flag wrong.");
  a_pre_all_close: assert property (@(posedge clk) disable iff (!nrst)
    (pre_pulse && pre_all) |-> open_banks[cmd_rank] == 8'h00)
    else $error("Precharge all left a bank open.");
  a_chop_beats: assert property (@(posedge clk) disable iff (!nrst)
    (read_pulse && mode_image[cmd_rank][0][1:0] == ddr3_cai_pkg::BL_OTF)
    |-> burst_length == ($past(q_reg.s2.addr[12]) ? 4'h8 : 4'h4))
    else $error("Chop bit did not set burst length.");
  a_mode_load: assert property (@(posedge clk) disable iff (!nrst)
    mode_pulse |-> mode_image[cmd_rank][mode_index] == $past(q_reg.s2.addr))
    else $error("Mode register not loaded.");
  a_masked_cs: assert property (@(posedge clk) disable iff (!nrst)
    (q_reg.s2.cs_n == 2'h3) |=> !(act_pulse || read_pulse || write_pulse || pre_pulse))
    else $error("Command taken with chip select high.");
endmodule

// >>> inc/ddr3_cai_pkg.sv
// Package with widths, encodings and power states of the DDR3 command input block.
package ddr3_cai_pkg;
  localparam int RANKS = 2;
  localparam int ADDR_W = 15;
  localparam int BANK_W = 3;
  localparam int BANKS = 8;
  localparam int COL_W = 11;
  localparam int MODE_REGS = 4;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int COL_HI_BIT = 11;
  localparam int BL_LSB = 0;
  localparam logic [1:0] BL_FIXED_8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED_4 = 2'h2;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  localparam logic [ADDR_W-1:0] MODE_RESET = 15'h0000;

  // Command code is {row strobe, column strobe, write enable}, active low.
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_ZQ = 3'b110,
    CMD_NOP = 3'b111
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_PRE_PD = 2'b01,
    PWR_ACT_PD = 2'b10,
    PWR_SELF_REF = 2'b11
  } pwr_t;
endpackage

// >>> inc/rank_pwr_if.sv
// Interface between the command front end and one rank's power state machine.
`timescale 1ns/10ps
interface rank_pwr_if;
  logic cke;
  logic refresh_sel;
  logic banks_idle;
  ddr3_cai_pkg::pwr_t state;
  logic core_en;
  logic cmd_buf_en;
  logic ck_buf_en;
  modport rank (input cke, refresh_sel, banks_idle, output state, core_en, cmd_buf_en, ck_buf_en);
  modport ctrl (output cke, refresh_sel, banks_idle, input state, core_en, cmd_buf_en, ck_buf_en);
endinterface

// >>> rtl/rank_power.sv
// Power-down and self-refresh state machine of one rank, with buffer enables.
`timescale 1ns/10ps
module rank_power (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Link to the front end.
  rank_pwr_if.rank p
);
  typedef struct packed {
    ddr3_cai_pkg::pwr_t state;
    logic core_en;
    logic cmd_buf_en;
    logic ck_buf_en;
  } pwr_state_t;

  pwr_state_t st_reg;
  pwr_state_t st_next;

  // Next state from the synchronised clock enable and the bank state.
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      ddr3_cai_pkg::PWR_ACTIVE: begin
        if (!p.cke) begin
          if (p.banks_idle && p.refresh_sel) begin
            st_next.state = ddr3_cai_pkg::PWR_SELF_REF;
          end else if (p.banks_idle) begin
            st_next.state = ddr3_cai_pkg::PWR_PRE_PD;
          end else begin
            st_next.state = ddr3_cai_pkg::PWR_ACT_PD;
          end
        end
      end
      ddr3_cai_pkg::PWR_PRE_PD, ddr3_cai_pkg::PWR_ACT_PD: begin
        if (p.cke) begin
          st_next.state = ddr3_cai_pkg::PWR_ACTIVE;
        end
      end
      ddr3_cai_pkg::PWR_SELF_REF: begin
        // Exit rides on the enable level only; no command sampling is involved.
        if (p.cke) begin
          st_next.state = ddr3_cai_pkg::PWR_ACTIVE;
        end
      end
    endcase
    st_next.core_en = (st_next.state == ddr3_cai_pkg::PWR_ACTIVE);
    st_next.cmd_buf_en = (st_next.state == ddr3_cai_pkg::PWR_ACTIVE);
    st_next.ck_buf_en = (st_next.state != ddr3_cai_pkg::PWR_SELF_REF);
  end

  // State register; every rank wakes fully enabled.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '{state: ddr3_cai_pkg::PWR_ACTIVE, core_en: 1'b1, cmd_buf_en: 1'b1,
                  ck_buf_en: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // Registered values out to the front end.
  assign p.state = st_reg.state;
  assign p.core_en = st_reg.core_en;
  assign p.cmd_buf_en = st_reg.cmd_buf_en;
  assign p.ck_buf_en = st_reg.ck_buf_en;

  a_sr_exit_wake: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.state == ddr3_cai_pkg::PWR_SELF_REF && p.cke)
    |=> (st_reg.state == ddr3_cai_pkg::PWR_ACTIVE) && st_reg.core_en)
    else $error("Self refresh did not exit on clock enable high.");
  a_active_pd_entry: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.state == ddr3_cai_pkg::PWR_ACTIVE && !p.cke && !p.banks_idle)
    |=> (st_reg.state == ddr3_cai_pkg::PWR_ACT_PD) && !st_reg.core_en)
    else $error("Open bank did not lead to active power-down.");
  a_sr_buffers_off: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.state == ddr3_cai_pkg::PWR_SELF_REF) |-> !p.ck_buf_en && !p.cmd_buf_en)
    else $error("Buffers alive during self refresh.");
  a_pd_clock_alive: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.state inside {ddr3_cai_pkg::PWR_PRE_PD, ddr3_cai_pkg::PWR_ACT_PD})
    |-> p.ck_buf_en && !p.cmd_buf_en)
    else $error("Wrong buffer set during power-down.");
endmodule

// >>> dv/ddr3_ctrl_model.sv
// Behavioural DDR3 controller that drives the command, address and clock-enable pins.
`timescale 1ns/10ps
module ddr3_ctrl_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Requests from the bench.
  input wire logic req_valid,
  input wire ddr3_cai_pkg::cmd_t req_cmd,
  input wire logic req_rank,
  input wire logic [2:0] req_bank,
  input wire logic [14:0] req_addr,
  input wire logic [1:0] cke_req,
  input wire logic [1:0] odt_req,
  // Pins towards the device.
  output logic [1:0] cke,
  output logic [1:0] cs_n,
  output logic [1:0] odt,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank_addr,
  output logic [14:0] addr
);
  // Pins start deselected with clocks enabled.
  initial begin
    {cke, cs_n, odt} = 6'h3C;
    {ras_n, cas_n, we_n, bank_addr, addr} = 21'h0;
  end

  // Per-rank enables follow the bench; a request selects one rank for one cycle.
  always @(posedge clk) begin
    cke <= cke_req;
    odt <= odt_req;
    if (nrst && req_valid) begin
      cs_n <= req_rank ? 2'h1 : 2'h2;
      {ras_n, cas_n, we_n} <= req_cmd;
      bank_addr <= req_bank;
      addr <= req_addr;
    end else begin
      // A deselected bus shows the inverse of the last value, never a stale copy.
      cs_n <= 2'h3;
      {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
      bank_addr <= ~bank_addr;
      addr <= ~addr;
    end
  end
endmodule

// >>> dv/ddr3_cmd_addr_cke_inputs_tb_top.sv
// Self-checking bench for the DDR3 command, address and clock-enable front end.
`timescale 1ns/10ps
module ddr3_cmd_addr_cke_inputs_tb_top;
  typedef struct packed {
    logic [5:0] kind;
    logic rank;
    logic [2:0] bank;
    logic [14:0] val;
    logic flag;
    logic [3:0] bl;
    logic [31:0] due;
  } exp_t;
  logic clk, nrst, req_valid, req_rank, ras_n, cas_n, we_n, cmd_rank, pre_all;
  logic act_pulse, read_pulse, write_pulse, pre_pulse, mode_pulse, mode_error;
  logic auto_precharge_bit, dqs_out, dqs_oe, dq_prev;
  ddr3_cai_pkg::cmd_t req_cmd;
  logic [2:0] req_bank, bank_addr, cmd_bank;
  logic [14:0] req_addr, addr, row_addr;
  logic [1:0] cke_req, odt_req, cke, cs_n, odt, mode_index, odt_active, core_en;
  logic [1:0] cmd_buf_en, ck_buf_en;
  logic [10:0] col_addr;
  logic [3:0] burst_length;
  logic [1:0][7:0] open_banks, ob;
  logic [1:0][3:0][14:0] mode_image, mi;
  ddr3_cai_pkg::pwr_t [1:0] pwr_state;
  logic [31:0] rnd, cyc;
  exp_t exq[$];
  int n_errors, checks, n, tg;

  ddr3_ctrl_model ctrl_u (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_rank(req_rank), .req_bank(req_bank), .req_addr(req_addr), .cke_req(cke_req),
    .odt_req(odt_req), .cke(cke), .cs_n(cs_n), .odt(odt), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_addr(bank_addr), .addr(addr));
  ddr3_cmd_addr_cke_inputs dut_u (.clk(clk), .nrst(nrst), .cke(cke), .cs_n(cs_n), .odt(odt),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
    .act_pulse(act_pulse), .read_pulse(read_pulse), .write_pulse(write_pulse),
    .pre_pulse(pre_pulse), .mode_pulse(mode_pulse), .mode_error(mode_error),
    .cmd_rank(cmd_rank), .cmd_bank(cmd_bank), .row_addr(row_addr), .col_addr(col_addr),
    .auto_precharge_bit(auto_precharge_bit), .pre_all(pre_all),
    .burst_length(burst_length), .mode_index(mode_index), .open_banks(open_banks),
    .mode_image(mode_image), .odt_active(odt_active), .pwr_state(pwr_state),
    .core_en(core_en), .cmd_buf_en(cmd_buf_en), .ck_buf_en(ck_buf_en),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe));

  // Clock and a free-running edge count for latency checks.
  initial begin
    clk = 1'b0;
    cyc = 32'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 32'h1;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Presents one command for one cycle and notes its expected answer if it is accepted.
  task automatic issue(input ddr3_cai_pkg::cmd_t c, input logic r, input logic [2:0] b,
                       input logic [14:0] a, input logic ok);
    exp_t e;
    logic [1:0] bm;
    e = '0;
    bm = mi[r][0][1:0];
    e.rank = r;
    e.bank = b;
    e.due = cyc + 32'h5;
    e.val = a;
    e.flag = a[10];
    e.bl = (bm == 2'h2 || (bm == 2'h1 && !a[12])) ? 4'h4 : 4'h8;
    if (ok) begin
      case (c)
        ddr3_cai_pkg::CMD_ACT: begin
          e.kind = 6'h20;
          ob[r][b] = 1'b1;
        end
        ddr3_cai_pkg::CMD_RD, ddr3_cai_pkg::CMD_WR: begin
          e.kind = (c == ddr3_cai_pkg::CMD_RD) ? 6'h10 : 6'h08;
          e.val = {4'h0, a[11], a[9:0]};
          if (a[10]) ob[r][b] = 1'b0;
        end
        ddr3_cai_pkg::CMD_PRE: begin
          e.kind = 6'h04;
          if (a[10]) ob[r] = 8'h00;
          else ob[r][b] = 1'b0;
        end
        ddr3_cai_pkg::CMD_MRS: begin
          e.kind = b[2] ? 6'h01 : 6'h02;
          if (!b[2]) mi[r][b[1:0]] = a;
        end
        default: e.kind = 6'h00;
      endcase
      if (e.kind != 6'h00) exq.push_back(e);
    end
    req_valid <= 1'b1;
    req_cmd <= c;
    {req_rank, req_bank, req_addr} <= {r, b, a};
    @(posedge clk);
  endtask

  // Leaves the bus idle for a number of cycles.
  task automatic idle(input int k);
    req_valid <= 1'b0;
    repeat (k) @(posedge clk);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Checking
  // -----------------------------------------------------------------
  // Each decoded pulse takes the oldest note and compares its fields and latency.
  always @(posedge clk) begin
    exp_t e;
    logic [5:0] k;
    #1;
    k = {act_pulse, read_pulse, write_pulse, pre_pulse, mode_pulse, mode_error};
    if (k != 6'h0) begin
      if (exq.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = exq.pop_front();
        chk(k, e.kind);
        chk(cyc, e.due);
        chk(cmd_rank, e.rank);
        if (e.kind[5] | e.kind[4] | e.kind[3]) chk(cmd_bank, e.bank);
        if (e.kind[5]) chk(row_addr, e.val);
        if (e.kind[4] | e.kind[3]) begin
          chk({col_addr, auto_precharge_bit}, {e.val[10:0], e.flag});
          chk(burst_length, e.bl);
        end
        if (e.kind[2]) begin
          chk(pre_all, e.flag);
          if (!e.flag) chk(cmd_bank, e.bank);
        end
        if (e.kind[1]) begin
          chk(mode_index, e.bank[1:0]);
          chk(mode_image[e.rank][e.bank[1:0]], e.val);
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Stimulus
  // -----------------------------------------------------------------
  initial begin
    {nrst, req_valid, req_rank, req_bank, req_addr, odt_req} = '0;
    req_cmd = ddr3_cai_pkg::CMD_NOP;
    cke_req = 2'h3;
    {rnd, ob, mi, n_errors, checks} = {32'hC565, 16'h0, 120'h0, 64'h0};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    idle(4);
    for (int m = 1; m < 4; m++) begin
      rnd = lfsr(rnd);
      issue(ddr3_cai_pkg::CMD_MRS, m[0], 3'(m), rnd[14:0], 1'b1);
    end
    issue(ddr3_cai_pkg::CMD_MRS, 1'b0, 3'h5, rnd[15:1], 1'b1);
    issue(ddr3_cai_pkg::CMD_ACT, 1'b0, 3'h3, rnd[16:2], 1'b1);
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      issue(ddr3_cai_pkg::CMD_MRS, 1'b0, 3'h0, {rnd[14:2], 2'(m)}, 1'b1);
      issue(ddr3_cai_pkg::CMD_RD, 1'b0, 3'h3, {rnd[14:13], 2'h2, 1'b0, rnd[9:0]}, 1'b1);
      issue(ddr3_cai_pkg::CMD_WR, 1'b0, 3'h3, {rnd[14:13], 2'h0, 1'b0, rnd[9:0]}, 1'b1);
    end
    idle(20);
    issue(ddr3_cai_pkg::CMD_RD, 1'b0, 3'h3, rnd[14:0] & 15'h7BFF, 1'b1);
    // Drop the request at once so the read is sent exactly once.
    req_valid <= 1'b0;
    n = 0;
    tg = 0;
    dq_prev = dqs_out;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      #1;
      if (dqs_oe === 1'b1) n++;
      if (dqs_out !== dq_prev) tg++;
      dq_prev = dqs_out;
    end
    chk(n, 8);
    chk(tg, 8);
    idle(1);
    issue(ddr3_cai_pkg::CMD_WR, 1'b0, 3'h3, 15'h0400, 1'b1);
    issue(ddr3_cai_pkg::CMD_ACT, 1'b1, 3'h1, rnd[15:1], 1'b1);
    issue(ddr3_cai_pkg::CMD_ACT, 1'b1, 3'h5, rnd[17:3], 1'b1);
    issue(ddr3_cai_pkg::CMD_PRE, 1'b1, 3'h1, 15'h7BFF, 1'b1);
    idle(6);
    chk(open_banks, ob);
    issue(ddr3_cai_pkg::CMD_PRE, 1'b1, 3'h0, 15'h0400, 1'b1);
    issue(ddr3_cai_pkg::CMD_ACT, 1'b0, 3'h2, rnd[14:0], 1'b1);
    idle(6);
    chk(open_banks, ob);
    cke_req <= 2'h2;
    odt_req <= 2'h3;
    idle(6);
    chk(pwr_state[0], ddr3_cai_pkg::PWR_ACT_PD);
    chk({core_en[0], cmd_buf_en[0], ck_buf_en[0], odt_active[0]}, 4'h3);
    issue(ddr3_cai_pkg::CMD_ACT, 1'b0, 3'h4, rnd[14:0], 1'b0);
    cke_req <= 2'h3;
    idle(6);
    chk(pwr_state[0], ddr3_cai_pkg::PWR_ACTIVE);
    chk(open_banks, ob);
    issue(ddr3_cai_pkg::CMD_PRE, 1'b0, 3'h0, 15'h0400, 1'b1);
    idle(4);
    cke_req <= 2'h2;
    idle(6);
    chk(pwr_state[0], ddr3_cai_pkg::PWR_PRE_PD);
    cke_req <= 2'h3;
    idle(6);
    cke_req <= 2'h2;
    issue(ddr3_cai_pkg::CMD_REF, 1'b0, 3'h0, 15'h0000, 1'b1);
    idle(6);
    chk(pwr_state[0], ddr3_cai_pkg::PWR_SELF_REF);
    chk({core_en[0], cmd_buf_en[0], ck_buf_en[0], odt_active[0]}, 4'h0);
    chk({pwr_state[1], odt_active[1]}, {ddr3_cai_pkg::PWR_ACTIVE, 1'b1});
    cke_req <= 2'h3;
    idle(6);
    chk({pwr_state[0], core_en[0], cmd_buf_en[0], ck_buf_en[0]}, 5'h07);
    for (int i = 0; i < 8; i++) chk(mode_image[i[2]][i[1:0]], mi[i[2]][i[1:0]]);
    for (int i = 0; i < 20 && exq.size() != 0; i++) @(posedge clk);
    if (exq.size() != 0) chk(exq.size(), 0);
    finish_test();
  end
endmodule
